// [core/boot_sel_pkg.sv]
// Purpose: shared constants and types of the boot source selector
// Assumes: four-bit boot source field, four boot select straps
// Notes:   pin function codes are local encodings of the pin mux
package boot_sel_pkg;

  // boot memory geometry
  localparam int BOOT_MEM_BYTES = 65536;
  localparam int WORD_BYTES     = 4;
  localparam int BOOT_MEM_WORDS = BOOT_MEM_BYTES / WORD_BYTES;
  localparam int BOOT_ADDR_W    = $clog2(BOOT_MEM_WORDS);
  localparam int WORD_W         = 8 * WORD_BYTES;

  // boot source field codes
  localparam logic [3:0] FIELD_PINS     = 4'h0;
  localparam logic [3:0] FIELD_SER0     = 4'h1;
  localparam logic [3:0] FIELD_QFLASH   = 4'h2;
  localparam logic [3:0] FIELD_EXT8     = 4'h3;
  localparam logic [3:0] FIELD_EXT16    = 4'h4;
  localparam logic [3:0] FIELD_EXT32    = 4'h5;
  localparam logic [3:0] FIELD_USB1ST   = 4'h6;
  localparam logic [3:0] FIELD_USB2ND   = 4'h7;
  localparam logic [3:0] FIELD_SPIFLASH = 4'h8;
  localparam logic [3:0] FIELD_SER3     = 4'h9;

  // strap codes, pin3 down to pin0, low reads as zero
  localparam logic [3:0] STRAP_SER0     = 4'h0;
  localparam logic [3:0] STRAP_QFLASH   = 4'h1;
  localparam logic [3:0] STRAP_EXT8     = 4'h2;
  localparam logic [3:0] STRAP_EXT16    = 4'h3;
  localparam logic [3:0] STRAP_EXT32    = 4'h4;
  localparam logic [3:0] STRAP_USB1ST   = 4'h5;
  localparam logic [3:0] STRAP_USB2ND   = 4'h6;
  localparam logic [3:0] STRAP_SPIFLASH = 4'h7;
  localparam logic [3:0] STRAP_SER3     = 4'h8;

  // cycles after reset release before straps are trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // external memory data width codes
  localparam logic [1:0] EXT_W8  = 2'h0;
  localparam logic [1:0] EXT_W16 = 2'h1;
  localparam logic [1:0] EXT_W32 = 2'h2;

  // shared flash pins and their function codes
  localparam int SHARED_PINS   = 6;
  localparam int FUNC_W        = 3;
  localparam int PIN_SCK_IDX   = 0;
  localparam int PIN_SSEL_IDX  = 3;
  localparam int PIN_MISO_IDX  = 4;
  localparam int PIN_MOSI_IDX  = 5;
  localparam logic [2:0] FUNC_GPIO   = 3'h0;
  localparam logic [2:0] FUNC_SSP    = 3'h2;
  localparam logic [2:0] FUNC_QFLASH = 3'h3;

  typedef enum logic [3:0] {
    MODE_NONE,
    MODE_SER0,
    MODE_QFLASH,
    MODE_EXT8,
    MODE_EXT16,
    MODE_EXT32,
    MODE_USB1ST,
    MODE_USB2ND,
    MODE_SPIFLASH,
    MODE_SER3,
    MODE_BAD
  } boot_mode_type;

endpackage

// [core/strap_sync.sv]
// Purpose: two-flop synchroniser for the strap pins
// Assumes: pins are asynchronous to mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module strap_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // pins and synchronised copy
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type s_q;
  sync_state_type s_d;

  always_comb
  begin
    s_d.meta   = pinIn;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign pinSync = s_q.stable;

endmodule

// [core/boot_mem.sv]
// Purpose: internal boot memory holding the boot code
// Assumes: one word read port, one word load port
// Notes:   the array is not reset, only its read data and valid flops are
`timescale 1ns/1ps
module boot_mem #(
  parameter int WORDS = boot_sel_pkg::BOOT_MEM_WORDS,
  parameter int AW    = boot_sel_pkg::BOOT_ADDR_W,
  parameter int DW    = boot_sel_pkg::WORD_W
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // image load
  input  wire logic          loadEn,
  input  wire logic [AW-1:0] loadAddr,
  input  wire logic [DW-1:0] loadData,
  // fetch
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData,
  output logic               rdValid
);

  typedef struct packed {
    logic [DW-1:0] data;
    logic          valid;
  } mem_state_type;

  logic [DW-1:0] store [WORDS];
  mem_state_type s_q;
  mem_state_type s_d;

  always_comb
  begin
    s_d.valid = rdEn;
    s_d.data  = rdEn ? store[rdAddr] : s_q.data;
  end

  always_ff @(posedge mclk)
  begin
    if (loadEn)
      store[loadAddr] <= loadData;
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign rdData  = s_q.data;
  assign rdValid = s_q.valid;

endmodule

// [core/boot_source_selector.sv]
// Purpose: reset-time boot source choice and boot memory fetch
// Assumes: straps are asynchronous pins, field inputs are on mclk
// Notes:   choice is taken once per reset and held until next reset
//
// Behaviour
// [RL1] first fetches after reset hit boot memory
// [RL2] boot memory holds 64 kilobytes
// [RL3] selection only when strap enable low
// [RL4] zero or blank field defers to straps
// [RL5] field 0001 picks serial port zero programming
// [RL6] field 0010 picks quad flash boot
// [RL7] fields 0011-0101 pick 8/16/32-bit external memory
// [RL8] fields 0110, 0111 pick first, second USB
// [RL9] field 1000 picks serial flash, sync port
// [RL10] field 1001 picks serial port three programming
// [RL11] boot sets shared pin functions per source
// [RL12] quad flash and sync port functions differ
// [RL13] straps 0000-0101 pick first six sources
// [RL14] straps 0110-1000 pick remaining three sources
// [RL15] straps sampled once, choice held
`timescale 1ns/1ps
module boot_source_selector #(
  parameter int AW = boot_sel_pkg::BOOT_ADDR_W,
  parameter int DW = boot_sel_pkg::WORD_W
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // strap pins
  input  wire logic          bootStrapEnablePin,
  input  wire logic          bootSelectPin3,
  input  wire logic          bootSelectPin2,
  input  wire logic          bootSelectPin1,
  input  wire logic          bootSelectPin0,
  // one-time-programmable field
  input  wire logic          otpProgrammed,
  input  wire logic [3:0]    bootSourceField,
  // processor fetch and remap
  input  wire logic          fetchReq,
  input  wire logic [AW-1:0] fetchAddr,
  input  wire logic          remapDone,
  output logic      [DW-1:0] fetchData,
  output logic               fetchValid,
  // boot image load
  input  wire logic          loadEn,
  input  wire logic [AW-1:0] loadAddr,
  input  wire logic [DW-1:0] loadData,
  // boot choice
  output logic               cpuRunEn,
  output logic               bootFetchSel,
  output logic               bootDone,
  output logic               selectionActive,
  output logic               choiceFromField,
  output logic               badCode,
  output logic [3:0]         bootMode,
  // peripheral enables
  output logic               serialPortZeroEn,
  output logic               serialPortThreeEn,
  output logic               quadFlashEn,
  output logic               syncSerialZeroEn,
  output logic               extMemEn,
  output logic [1:0]         extMemWidth,
  output logic               firstUsbEn,
  output logic               secondUsbEn,
  output logic [17:0]        sharedPinFunc
);

  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_SAMPLE,
    ST_HOLD
  } phase_type;

  typedef struct packed {
    phase_type                  phase;
    logic [1:0]                 settle;
    boot_sel_pkg::boot_mode_type mode;
    logic                       active;
    logic                       fromField;
    logic                       run;
    logic                       fetchSel;
    logic [1:0]                 width;
    logic [17:0]                pinFunc;
    logic                       ser0En;
    logic                       ser3En;
    logic                       qflashEn;
    logic                       syncEn;
    logic                       extEn;
    logic                       usb1En;
    logic                       usb2En;
    logic                       bad;
  } sel_state_type;

  sel_state_type s_q;
  sel_state_type s_d;
  logic [4:0]    strapSync;
  logic          memRdEn;

  // [RL5] [RL6] [RL7] [RL8] [RL9] [RL10] field decode
  function automatic boot_sel_pkg::boot_mode_type fieldMode(
    input logic [3:0] code
  );
    unique case (code)
      boot_sel_pkg::FIELD_SER0:     fieldMode = boot_sel_pkg::MODE_SER0;
      boot_sel_pkg::FIELD_QFLASH:   fieldMode = boot_sel_pkg::MODE_QFLASH;
      boot_sel_pkg::FIELD_EXT8:     fieldMode = boot_sel_pkg::MODE_EXT8;
      boot_sel_pkg::FIELD_EXT16:    fieldMode = boot_sel_pkg::MODE_EXT16;
      boot_sel_pkg::FIELD_EXT32:    fieldMode = boot_sel_pkg::MODE_EXT32;
      boot_sel_pkg::FIELD_USB1ST:   fieldMode = boot_sel_pkg::MODE_USB1ST;
      boot_sel_pkg::FIELD_USB2ND:   fieldMode = boot_sel_pkg::MODE_USB2ND;
      boot_sel_pkg::FIELD_SPIFLASH:
        fieldMode = boot_sel_pkg::MODE_SPIFLASH;
      boot_sel_pkg::FIELD_SER3:     fieldMode = boot_sel_pkg::MODE_SER3;
      default:                      fieldMode = boot_sel_pkg::MODE_BAD;
    endcase
  endfunction

  // [RL13] [RL14] strap decode
  function automatic boot_sel_pkg::boot_mode_type strapMode(
    input logic [3:0] code
  );
    unique case (code)
      boot_sel_pkg::STRAP_SER0:     strapMode = boot_sel_pkg::MODE_SER0;
      boot_sel_pkg::STRAP_QFLASH:   strapMode = boot_sel_pkg::MODE_QFLASH;
      boot_sel_pkg::STRAP_EXT8:     strapMode = boot_sel_pkg::MODE_EXT8;
      boot_sel_pkg::STRAP_EXT16:    strapMode = boot_sel_pkg::MODE_EXT16;
      boot_sel_pkg::STRAP_EXT32:    strapMode = boot_sel_pkg::MODE_EXT32;
      boot_sel_pkg::STRAP_USB1ST:   strapMode = boot_sel_pkg::MODE_USB1ST;
      boot_sel_pkg::STRAP_USB2ND:   strapMode = boot_sel_pkg::MODE_USB2ND;
      boot_sel_pkg::STRAP_SPIFLASH:
        strapMode = boot_sel_pkg::MODE_SPIFLASH;
      boot_sel_pkg::STRAP_SER3:     strapMode = boot_sel_pkg::MODE_SER3;
      default:                      strapMode = boot_sel_pkg::MODE_BAD;
    endcase
  endfunction

  // one pin function code into the packed pin vector
  function automatic logic [17:0] setFunc(
    input logic [17:0] vec,
    input int          idx,
    input logic [2:0]  func
  );
    logic [17:0] r;
    r = vec;
    r[idx*boot_sel_pkg::FUNC_W +: boot_sel_pkg::FUNC_W] = func;
    setFunc = r;
  endfunction

  // [RL11] [RL12] shared pin functions per source
  function automatic logic [17:0] pinFuncFor(
    input boot_sel_pkg::boot_mode_type m
  );
    logic [17:0] v;
    v = '0;
    if (m == boot_sel_pkg::MODE_QFLASH)
    begin
      for (int i = 0; i < boot_sel_pkg::SHARED_PINS; i++)
        v = setFunc(v, i, boot_sel_pkg::FUNC_QFLASH);
    end
    else if (m == boot_sel_pkg::MODE_SPIFLASH)
    begin
      v = setFunc(v, boot_sel_pkg::PIN_SCK_IDX, boot_sel_pkg::FUNC_SSP);
      v = setFunc(v, boot_sel_pkg::PIN_SSEL_IDX, boot_sel_pkg::FUNC_SSP);
      v = setFunc(v, boot_sel_pkg::PIN_MISO_IDX, boot_sel_pkg::FUNC_SSP);
      v = setFunc(v, boot_sel_pkg::PIN_MOSI_IDX, boot_sel_pkg::FUNC_SSP);
    end
    pinFuncFor = v;
  endfunction

  // [RL15] straps cross two flops before use
  // reset clears both stages, so settling must cover the refill
  strap_sync #(
    .WIDTH (5)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pinIn   ({bootStrapEnablePin, bootSelectPin3, bootSelectPin2,
                bootSelectPin1, bootSelectPin0}),
    .pinSync (strapSync)
  );

  always_comb
  begin
    boot_sel_pkg::boot_mode_type m;
    logic                        fromF;
    m     = boot_sel_pkg::MODE_NONE;
    fromF = 1'b0;
    s_d   = s_q;
    unique case (s_q.phase)
      ST_SETTLE:
      begin
        // synchroniser output is stale until it has refilled
        s_d.settle = s_q.settle + 2'h1;
        if (s_q.settle == boot_sel_pkg::SETTLE_CYCLES - 2'h1)
          s_d.phase = ST_SAMPLE;
      end
      ST_SAMPLE:
      begin
        // straps and field read once here, later changes ignored
        // [RL3] enable strap low gates selection
        if (!strapSync[4])
        begin
          // [RL4] blank or zero field uses straps
          if (otpProgrammed &&
              bootSourceField != boot_sel_pkg::FIELD_PINS)
          begin
            m     = fieldMode(bootSourceField);
            fromF = 1'b1;
          end
          else
            m = strapMode(strapSync[3:0]);
        end
        s_d.mode      = m;
        s_d.fromField = fromF;
        s_d.active    = !strapSync[4];
        s_d.pinFunc   = pinFuncFor(m);
        // decoded enables registered so every output is a flop
        s_d.ser0En    = m == boot_sel_pkg::MODE_SER0;
        s_d.ser3En    = m == boot_sel_pkg::MODE_SER3;
        s_d.qflashEn  = m == boot_sel_pkg::MODE_QFLASH;
        s_d.syncEn    = m == boot_sel_pkg::MODE_SPIFLASH;
        s_d.extEn     = m == boot_sel_pkg::MODE_EXT8 ||
                        m == boot_sel_pkg::MODE_EXT16 ||
                        m == boot_sel_pkg::MODE_EXT32;
        s_d.usb1En    = m == boot_sel_pkg::MODE_USB1ST;
        s_d.usb2En    = m == boot_sel_pkg::MODE_USB2ND;
        s_d.bad       = m == boot_sel_pkg::MODE_BAD;
        // [RL7] external memory data width
        unique case (m)
          boot_sel_pkg::MODE_EXT16: s_d.width = boot_sel_pkg::EXT_W16;
          boot_sel_pkg::MODE_EXT32: s_d.width = boot_sel_pkg::EXT_W32;
          default:                  s_d.width = boot_sel_pkg::EXT_W8;
        endcase
        s_d.run   = 1'b1;
        s_d.phase = ST_HOLD;
      end
      ST_HOLD:
      begin
        // only the fetch mapping may still change after the choice
        // [RL1] boot memory mapped until software remaps
        if (remapDone)
          s_d.fetchSel = 1'b0;
      end
      default:
        s_d.phase = ST_SETTLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.phase    <= ST_SETTLE;
      s_q.mode     <= boot_sel_pkg::MODE_NONE;
      // [RL1] fetch path starts on boot memory
      s_q.fetchSel <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // [RL1] fetches served by boot memory while mapped
  assign memRdEn = fetchReq && s_q.run && s_q.fetchSel;

  // [RL2] 64 kB boot memory
  boot_mem #(
    .WORDS (boot_sel_pkg::BOOT_MEM_WORDS),
    .AW    (AW),
    .DW    (DW)
  ) u_mem (
    .mclk     (mclk),
    .rst      (rst),
    .loadEn   (loadEn),
    .loadAddr (loadAddr),
    .loadData (loadData),
    .rdEn     (memRdEn),
    .rdAddr   (fetchAddr),
    .rdData   (fetchData),
    .rdValid  (fetchValid)
  );

  // every output is a plain copy of a state flop
  assign cpuRunEn          = s_q.run;
  assign bootFetchSel      = s_q.fetchSel;
  assign bootDone          = s_q.run;
  assign selectionActive   = s_q.active;
  assign choiceFromField   = s_q.fromField;
  assign badCode           = s_q.bad;
  assign bootMode          = s_q.mode;
  assign serialPortZeroEn  = s_q.ser0En;
  assign serialPortThreeEn = s_q.ser3En;
  assign quadFlashEn       = s_q.qflashEn;
  assign syncSerialZeroEn  = s_q.syncEn;
  assign extMemEn          = s_q.extEn;
  assign extMemWidth       = s_q.width;
  assign firstUsbEn        = s_q.usb1En;
  assign secondUsbEn       = s_q.usb2En;
  assign sharedPinFunc     = s_q.pinFunc;

endmodule

// [tb/board_straps.sv]
// Purpose: board strap resistors feeding the boot pins
// Assumes: straps stay put while the board is powered
// Notes:   pins are driven hard, a strapped pin never floats
`timescale 1ns/1ps
module board_straps (
  // board setting
  input  wire logic       selectOff,
  input  wire logic [3:0] strapCode,
  // strap pins
  output logic            bootStrapEnablePin,
  output logic            bootSelectPin3,
  output logic            bootSelectPin2,
  output logic            bootSelectPin1,
  output logic            bootSelectPin0
);
  assign bootStrapEnablePin = selectOff;
  assign {bootSelectPin3, bootSelectPin2,
          bootSelectPin1, bootSelectPin0} = strapCode;
endmodule

// [tb/boot_source_selector_assertions.sv]
// Purpose: port checks of the boot source selector
// Assumes: one clock, synchronous reset
// Notes:   pin function words are six 3-bit fields
`timescale 1ns/1ps
module boot_source_selector_checker (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // fetch
  input wire logic        fetchReq,
  input wire logic        remapDone,
  input wire logic        fetchValid,
  // boot choice
  input wire logic        cpuRunEn,
  input wire logic        bootFetchSel,
  input wire logic        selectionActive,
  input wire logic [3:0]  bootMode,
  input wire logic        quadFlashEn,
  input wire logic        syncSerialZeroEn,
  input wire logic        extMemEn,
  input wire logic [1:0]  extMemWidth,
  input wire logic [17:0] sharedPinFunc
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_fetch_sel: assert property (
    $fell(rst) |-> bootFetchSel) else $error("boot memory not mapped");
  a_valid_has_cause: assert property (
    fetchValid |-> $past(fetchReq && cpuRunEn && bootFetchSel))
    else $error("fetch answered without a taken request");
  a_remap_unmaps: assert property (
    remapDone |=> !bootFetchSel) else $error("remap ignored");
  a_choice_held: assert property (
    cpuRunEn |=> cpuRunEn && $stable(bootMode) && $stable(sharedPinFunc))
    else $error("boot choice changed");
  a_strap_off_none: assert property (
    cpuRunEn && !selectionActive |-> bootMode == 4'h0)
    else $error("mode chosen with selection off");
  a_qflash_pins: assert property (
    quadFlashEn |-> sharedPinFunc == 18'h1b6db)
    else $error("quad flash pin functions wrong");
  a_spi_pins: assert property (
    syncSerialZeroEn |-> sharedPinFunc == 18'h12402)
    else $error("sync port pin functions wrong");
  a_ext_width: assert property (
    extMemEn |-> {2'h0, extMemWidth} == bootMode - 4'h3)
    else $error("external bus width wrong");
  a_choice_in_time: assert property (
    $fell(rst) |-> !cpuRunEn ##[1:5] cpuRunEn)
    else $error("boot choice not taken in time");
endmodule

bind boot_source_selector boot_source_selector_checker i_chk (
  .mclk             (mclk),
  .rst              (rst),
  .fetchReq         (fetchReq),
  .remapDone        (remapDone),
  .fetchValid       (fetchValid),
  .cpuRunEn         (cpuRunEn),
  .bootFetchSel     (bootFetchSel),
  .selectionActive  (selectionActive),
  .bootMode         (bootMode),
  .quadFlashEn      (quadFlashEn),
  .syncSerialZeroEn (syncSerialZeroEn),
  .extMemEn         (extMemEn),
  .extMemWidth      (extMemWidth),
  .sharedPinFunc    (sharedPinFunc)
);

// [tb/boot_source_selector_tb.sv]
// Purpose: self-checking bench of the boot source selector
// Assumes: straps and field steady from reset release
// Notes:   every chk call reboots, so each reset path is walked
`timescale 1ns/1ps
module boot_source_selector_tb;
  logic mclk, fetchValid, cpuRunEn, bootFetchSel, bootDone;
  logic rst = 1'b1, selectOff = 1'b0, otpProgrammed = 1'b0;
  logic [3:0] strapCode = 4'h0, bootSourceField = 4'h0, bootMode;
  logic fetchReq = 1'b0, remapDone = 1'b0, loadEn = 1'b0;
  logic [13:0] fetchAddr = 14'h0000, loadAddr = 14'h0000;
  logic [31:0] loadData = 32'h0, fetchData;
  logic bootStrapEnablePin, bootSelectPin3, bootSelectPin2;
  logic bootSelectPin1, bootSelectPin0, selectionActive;
  logic choiceFromField, badCode, serialPortZeroEn, serialPortThreeEn;
  logic quadFlashEn, syncSerialZeroEn, extMemEn, firstUsbEn, secondUsbEn;
  logic [1:0] extMemWidth;
  logic [17:0] sharedPinFunc;
  int fail_count = 0;
  int checks = 0;

  board_straps i_board (
    .selectOff          (selectOff),
    .strapCode          (strapCode),
    .bootStrapEnablePin (bootStrapEnablePin),
    .bootSelectPin3     (bootSelectPin3),
    .bootSelectPin2     (bootSelectPin2),
    .bootSelectPin1     (bootSelectPin1),
    .bootSelectPin0     (bootSelectPin0)
  );
  boot_source_selector i_dut (
    .mclk               (mclk),
    .rst                (rst),
    .bootStrapEnablePin (bootStrapEnablePin),
    .bootSelectPin3     (bootSelectPin3),
    .bootSelectPin2     (bootSelectPin2),
    .bootSelectPin1     (bootSelectPin1),
    .bootSelectPin0     (bootSelectPin0),
    .otpProgrammed      (otpProgrammed),
    .bootSourceField    (bootSourceField),
    .fetchReq           (fetchReq),
    .fetchAddr          (fetchAddr),
    .remapDone          (remapDone),
    .fetchData          (fetchData),
    .fetchValid         (fetchValid),
    .loadEn             (loadEn),
    .loadAddr           (loadAddr),
    .loadData           (loadData),
    .cpuRunEn           (cpuRunEn),
    .bootFetchSel       (bootFetchSel),
    .bootDone           (bootDone),
    .selectionActive    (selectionActive),
    .choiceFromField    (choiceFromField),
    .badCode            (badCode),
    .bootMode           (bootMode),
    .serialPortZeroEn   (serialPortZeroEn),
    .serialPortThreeEn  (serialPortThreeEn),
    .quadFlashEn        (quadFlashEn),
    .syncSerialZeroEn   (syncSerialZeroEn),
    .extMemEn           (extMemEn),
    .extMemWidth        (extMemWidth),
    .firstUsbEn         (firstUsbEn),
    .secondUsbEn        (secondUsbEn),
    .sharedPinFunc      (sharedPinFunc)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic conclude();
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  function automatic logic [3:0] expMode(input logic off, pr,
                                         input logic [3:0] f, c);
    if (off)
      return 4'h0;
    if (pr && f != 4'h0)
      return (f > 4'h9) ? 4'ha : f;
    return (c > 4'h8) ? 4'ha : c + 4'h1;
  endfunction

  // order: ser0 qflash ext usb1 usb2 spi ser3
  function automatic logic [6:0] expEn(input logic [3:0] m);
    case (m)
      4'h1: return 7'h40;
      4'h2: return 7'h20;
      4'h3, 4'h4, 4'h5: return 7'h10;
      4'h6: return 7'h08;
      4'h7: return 7'h04;
      4'h8: return 7'h02;
      4'h9: return 7'h01;
      default: return 7'h00;
    endcase
  endfunction

  // six 3-bit pin function fields, pin0 lowest
  function automatic logic [17:0] expPins(input logic [3:0] m);
    logic [17:0] v;
    v = 18'h0;
    if (m == 4'h2)
      for (int i = 0; i < boot_sel_pkg::SHARED_PINS; i++)
        v[i*3 +: 3] = boot_sel_pkg::FUNC_QFLASH;
    if (m == 4'h8)
    begin
      v[boot_sel_pkg::PIN_SCK_IDX*3 +: 3]  = boot_sel_pkg::FUNC_SSP;
      v[boot_sel_pkg::PIN_SSEL_IDX*3 +: 3] = boot_sel_pkg::FUNC_SSP;
      v[boot_sel_pkg::PIN_MISO_IDX*3 +: 3] = boot_sel_pkg::FUNC_SSP;
      v[boot_sel_pkg::PIN_MOSI_IDX*3 +: 3] = boot_sel_pkg::FUNC_SSP;
    end
    return v;
  endfunction

  task automatic boot(input logic off, pr, input logic [3:0] f, c);
    int n;
    @(negedge mclk);
    rst = 1'b1;
    selectOff = off;
    otpProgrammed = pr;
    bootSourceField = f;
    strapCode = c;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    n = 0;
    while (cpuRunEn !== 1'b1 && n < 12)
    begin
      @(negedge mclk);
      cmp(32'(fetchValid), 32'h0, "fetch before choice");
      n++;
    end
    // bound spent means the design hung
    if (n == 12)
    begin
      fail_count++;
      $display("CHECK FAILED %0t boot choice never taken", $time);
      conclude();
    end
  endtask

  task automatic chk(input logic off, pr, input logic [3:0] f, c);
    logic [3:0] m;
    m = expMode(off, pr, f, c);
    boot(off, pr, f, c);
    cmp(32'(bootMode), 32'(m), "boot mode");
    cmp(32'({serialPortZeroEn, quadFlashEn, extMemEn, firstUsbEn,
             secondUsbEn, syncSerialZeroEn, serialPortThreeEn}),
        32'(expEn(m)), "peripheral enables");
    cmp(32'(extMemWidth),
        (m inside {[4'h3:4'h5]}) ? 32'(m - 4'h3) : 0, "bus width");
    cmp(32'(selectionActive), 32'(!off), "selection flag");
    cmp(32'(choiceFromField), 32'(!off && pr && f != 4'h0),
        "field flag");
    cmp(32'(badCode), 32'(m == 4'ha), "bad code flag");
    cmp(32'(bootDone), 32'h1, "boot done");
    cmp(32'(bootFetchSel), 32'h1, "boot memory mapped");
    cmp(32'(sharedPinFunc), 32'(expPins(m)), "pin functions");
  endtask

  task automatic scn_field();
    for (int f = 1; f < 16; f++)
      chk(1'b0, 1'b1, 4'(f), 4'h7);
  endtask

  task automatic scn_straps();
    for (int c = 0; c < 16; c++)
      chk(1'b0, 1'b1, 4'h0, 4'(c));
    chk(1'b0, 1'b0, 4'h5, 4'h3);
  endtask

  task automatic scn_disable();
    chk(1'b1, 1'b1, 4'h2, 4'h1);
    chk(1'b1, 1'b0, 4'h0, 4'h7);
  endtask

  // late strap changes must not leak into a taken choice
  task automatic scn_hold();
    chk(1'b0, 1'b0, 4'h9, 4'h2);
    selectOff = 1'b1;
    strapCode = 4'h8;
    repeat (8) @(negedge mclk);
    cmp(32'(bootMode), 32'h3, "mode after strap change");
  endtask

  task automatic scn_fetch();
    fetchReq = 1'b1;
    boot(1'b0, 1'b1, 4'h2, 4'h0);
    fetchReq = 1'b0;
    loadEn = 1'b1;
    loadData = 32'h1234abcd;
    @(negedge mclk);
    loadAddr = 14'h3fff;
    loadData = 32'h5a5a0f0f;
    @(negedge mclk);
    loadEn = 1'b0;
    fetchReq = 1'b1;
    @(negedge mclk);
    fetchAddr = 14'h3fff;
    cmp(32'(fetchValid), 32'h1, "fetch valid");
    cmp(fetchData, 32'h1234abcd, "fetch first word");
    @(negedge mclk);
    cmp(fetchData, 32'h5a5a0f0f, "fetch top word");
    fetchReq = 1'b0;
    remapDone = 1'b1;
    @(negedge mclk);
    remapDone = 1'b0;
    fetchReq = 1'b1;
    @(negedge mclk);
    cmp(32'(bootFetchSel), 32'h0, "boot memory unmapped");
    cmp(32'(fetchValid), 32'h0, "fetch after remap");
    fetchReq = 1'b0;
  endtask

  initial
  begin
    scn_field();
    scn_straps();
    scn_disable();
    scn_hold();
    scn_fetch();
    conclude();
  end
endmodule
